/* File: src/owd_params.svh */
// Constants for the option word decoder: word field positions, register
// offsets, reset values and the nominal figures it reports.
// Assumes option words are 13 bits wide and held stable by the NV array.
`ifndef OWD_PARAMS_SVH
`define OWD_PARAMS_SVH

// ****************************************************************
// Option word field positions
// ****************************************************************
`define OWD_PROT_MSB 2
`define OWD_PROT_LSB 0
`define OWD_OSC_MSB 5
`define OWD_OSC_LSB 3
`define OWD_RSV1_BIT 12
`define OWD_TPIN_BIT 11
`define OWD_RSV0_BIT 10
`define OWD_HALT_BIT 9
`define OWD_TRIM_MSB 8
`define OWD_TRIM_LSB 4
`define OWD_RCF_MSB 3
`define OWD_RCF_LSB 2
`define OWD_LVR_MSB 1
`define OWD_LVR_LSB 0

// ****************************************************************
// Register byte offsets and reset values
// ****************************************************************
`define OWD_ADDR_OSC 12'h000
`define OWD_ADDR_CFG 12'h004
`define OWD_ADDR_LVR 12'h008
`define OWD_ADDR_ID 12'h00C
`define OWD_ADDR_CTRL 12'h010
`define OWD_CTRL_RST 1'h0

// ****************************************************************
// Nominal figures
// ****************************************************************
`define OWD_TRIM_NOM_NS 250
`define OWD_RC_KHZ_0 15'h0FA0
`define OWD_RC_KHZ_1 15'h3E80
`define OWD_RC_KHZ_2 15'h0DFC
`define OWD_RC_KHZ_3 15'h01C7
`define OWD_POR_MV 12'h7D0
`define OWD_LVR1_TRIP_MV 12'hA28
`define OWD_LVR1_REL_MV 12'hAF0
`define OWD_LVR2_TRIP_MV 12'hCE4
`define OWD_LVR2_REL_MV 12'hD7A
`define OWD_LVR3_TRIP_MV 12'hED8
`define OWD_LVR3_REL_MV 12'hF3C

`endif

/* File: src/owd_pkg.sv */
// Types shared by the option word decoder.
// Assumes nothing of its surroundings.
package owd_pkg;

    // Selected system clock source
    typedef enum logic [2:0]
    {
        crystal_mode,
        high_crystal_mode,
        low_crystal1_mode,
        low_crystal2_mode,
        internal_resistor_cap_osc,
        ext_resistor_cap_osc
    } owd_clk_src_type;

endpackage

/* File: src/owd_top.sv */
// Option word decoder: captures the three option words once after reset
// and turns them into static control settings, with an AHB-Lite view.
// Assumes the option word inputs are stable from power-up and synchronous
// to hclk; the bus sees decoded settings, plus word 2 unchanged as the ID when unprotected.
//
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "owd_params.svh"

module owd_top
    import owd_pkg::*;
#(
    parameter int WORD_W = 13
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WORD_W-1:0] opt_word0,
    input wire logic [WORD_W-1:0] opt_word1,
    input wire logic [WORD_W-1:0] opt_word2,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output owd_clk_src_type clk_src_q,
    output logic osc_out_en_q,
    output logic second_osc_gpio_q,
    output logic code_protect_en_q,
    output logic timer_clk_in_sel_q,
    output logic halt_allow_q,
    output logic [4:0] rc_trim_code_q,
    output logic [4:0] rc_trim_rank_q,
    output logic [1:0] rc_freq_sel_q,
    output logic [14:0] rc_nominal_khz_q,
    output logic lvr_en_q,
    output logic [11:0] lvr_trip_mv_q,
    output logic [11:0] lvr_release_mv_q,
    output logic [WORD_W-1:0] customer_id_q,
    output logic reserved_ok_q,
    output logic settings_valid_q
);

    // ****************************************************************
    // Decode functions
    // ****************************************************************

    // Clock source from the three-bit mode field
    function automatic owd_clk_src_type clk_src_f(input logic [2:0] m);
        owd_clk_src_type s;
        s = crystal_mode;
        case (m)
            3'h0: s = crystal_mode;
            3'h1: s = high_crystal_mode;
            3'h2: s = low_crystal1_mode;
            3'h3: s = low_crystal2_mode;
            3'h4, 3'h5: s = internal_resistor_cap_osc;
            3'h6, 3'h7: s = ext_resistor_cap_osc;
            default: s = crystal_mode;
        endcase
        return s;
    endfunction

    // Frequency rank of a trim code, 0 slowest (11111) to 31 fastest
    function automatic logic [4:0] trim_rank_f(input logic [4:0] c);
        logic [4:0] r;
        r = 5'h00;
        case (c[4:3])
            2'h3: r = {2'h0, ~c[2:0]};
            2'h1: r = {2'h1, ~c[2:0]};
            2'h0: r = {2'h2, c[2:0]};
            2'h2: r = {2'h3, c[2:0]};
            default: r = 5'h00;
        endcase
        return r;
    endfunction

    // Nominal internal RC frequency in kHz
    function automatic logic [14:0] rc_khz_f(input logic [1:0] s);
        logic [14:0] k;
        k = `OWD_RC_KHZ_0;
        case (s)
            2'h0: k = `OWD_RC_KHZ_0;
            2'h1: k = `OWD_RC_KHZ_1;
            2'h2: k = `OWD_RC_KHZ_2;
            2'h3: k = `OWD_RC_KHZ_3;
            default: k = `OWD_RC_KHZ_0;
        endcase
        return k;
    endfunction

    // Reset trip level in mV; with the detector off only power-on remains
    function automatic logic [11:0] trip_mv_f(input logic [1:0] s);
        logic [11:0] v;
        v = `OWD_POR_MV;
        case (s)
            2'h0: v = `OWD_POR_MV;
            2'h1: v = `OWD_LVR1_TRIP_MV;
            2'h2: v = `OWD_LVR2_TRIP_MV;
            2'h3: v = `OWD_LVR3_TRIP_MV;
            default: v = `OWD_POR_MV;
        endcase
        return v;
    endfunction

    // Reset release level in mV
    function automatic logic [11:0] rel_mv_f(input logic [1:0] s);
        logic [11:0] v;
        v = `OWD_POR_MV;
        case (s)
            2'h0: v = `OWD_POR_MV;
            2'h1: v = `OWD_LVR1_REL_MV;
            2'h2: v = `OWD_LVR2_REL_MV;
            2'h3: v = `OWD_LVR3_REL_MV;
            default: v = `OWD_POR_MV;
        endcase
        return v;
    endfunction

    // ****************************************************************
    // Option word capture
    // ****************************************************************

    logic [2:0] osc_f;
    logic [1:0] lvr_f;
    logic [1:0] rcf_f;
    logic [4:0] trim_f;
    logic view_en_q;
    logic bus_take;

    assign osc_f = opt_word0[`OWD_OSC_MSB:`OWD_OSC_LSB];
    assign lvr_f = opt_word1[`OWD_LVR_MSB:`OWD_LVR_LSB];
    assign rcf_f = opt_word1[`OWD_RCF_MSB:`OWD_RCF_LSB];
    assign trim_f = opt_word1[`OWD_TRIM_MSB:`OWD_TRIM_LSB];

    // Ports cannot be loaded under async reset, so the words are taken
    // at the first edge after release and then frozen until next reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            settings_valid_q <= 1'b0;
            clk_src_q <= crystal_mode;
            osc_out_en_q <= 1'b0;
            second_osc_gpio_q <= 1'b0;
            code_protect_en_q <= 1'b1;
            timer_clk_in_sel_q <= 1'b0;
            halt_allow_q <= 1'b0;
            rc_trim_code_q <= 5'h00;
            rc_trim_rank_q <= 5'h10;
            rc_freq_sel_q <= 2'h0;
            rc_nominal_khz_q <= `OWD_RC_KHZ_0;
            lvr_en_q <= 1'b0;
            lvr_trip_mv_q <= `OWD_POR_MV;
            lvr_release_mv_q <= `OWD_POR_MV;
            customer_id_q <= '0;
            reserved_ok_q <= 1'b0;
        end
        else if (!settings_valid_q)
        begin
            settings_valid_q <= 1'b1;
            clk_src_q <= clk_src_f(osc_f);
            osc_out_en_q <= osc_f[2] & osc_f[0];
            second_osc_gpio_q <= osc_f[2] & ~osc_f[0];
            code_protect_en_q <=
                |opt_word0[`OWD_PROT_MSB:`OWD_PROT_LSB];
            timer_clk_in_sel_q <= opt_word1[`OWD_TPIN_BIT];
            halt_allow_q <= ~opt_word1[`OWD_HALT_BIT];
            rc_trim_code_q <= trim_f;
            rc_trim_rank_q <= trim_rank_f(trim_f);
            rc_freq_sel_q <= rcf_f;
            rc_nominal_khz_q <= rc_khz_f(rcf_f);
            lvr_en_q <= |lvr_f;
            lvr_trip_mv_q <= trip_mv_f(lvr_f);
            lvr_release_mv_q <= rel_mv_f(lvr_f);
            customer_id_q <= opt_word2;
            // Flags a mis-programmed part; decoding goes on regardless
            reserved_ok_q <= opt_word1[`OWD_RSV1_BIT] &
                ~opt_word1[`OWD_RSV0_BIT];
        end
    end

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************

    // Decoded settings as a read-back word; only word 2 reaches the bus raw, as the ID when unprotected
    function automatic logic [31:0] rd_mux_f(input logic [11:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            `OWD_ADDR_OSC: d = {25'h0,
                second_osc_gpio_q, osc_out_en_q, 2'h0, clk_src_q};
            `OWD_ADDR_CFG: d = {5'h0, settings_valid_q, reserved_ok_q,
                rc_nominal_khz_q, rc_freq_sel_q, rc_trim_rank_q,
                halt_allow_q, timer_clk_in_sel_q, code_protect_en_q};
            `OWD_ADDR_LVR: d = {7'h0, lvr_release_mv_q, lvr_trip_mv_q,
                lvr_en_q};
            `OWD_ADDR_ID: d = code_protect_en_q ? 32'h0000_0000 :
                {{(32 - WORD_W){1'b0}}, customer_id_q};
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    logic wr_pend_q;
    logic [11:0] wr_addr_q;

    assign bus_take = hsel & hready & htrans[1];

    // Zero-wait slave: always ready, always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Read data is prepared at the address phase edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (bus_take && !hwrite)
        begin
            if (view_en_q || haddr[11:0] == `OWD_ADDR_CTRL)
            begin
                if (haddr[11:0] == `OWD_ADDR_CTRL)
                    hrdata <= {31'h0, view_en_q};
                else
                    hrdata <= rd_mux_f(haddr[11:0]);
            end
            else
                hrdata <= 32'h0000_0000;
        end
        else
            hrdata <= 32'h0000_0000;
    end

    // Write address phase held for the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
        end
        else
        begin
            wr_pend_q <= bus_take & hwrite;
            wr_addr_q <= haddr[11:0];
        end
    end

    // Only the view control is writable; option words stay out of reach
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            view_en_q <= `OWD_CTRL_RST;
        else if (wr_pend_q && wr_addr_q == `OWD_ADDR_CTRL)
            view_en_q <= hwdata[0];
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_capture;
        !settings_valid_q ##1 settings_valid_q;
    endsequence

    sequence s_held;
        settings_valid_q ##1 settings_valid_q;
    endsequence

    a_osc_mode_map: assert property (
        s_capture |-> clk_src_q == clk_src_f($past(osc_f)))
        else $error("clock source does not follow mode field");

    a_rc_pin_use: assert property (
        s_capture |-> osc_out_en_q == ($past(osc_f) == 3'h5 ||
            $past(osc_f) == 3'h7) && second_osc_gpio_q ==
            ($past(osc_f) == 3'h4 || $past(osc_f) == 3'h6))
        else $error("second oscillator pin use wrong");

    a_protect_capture: assert property (
        s_capture |-> code_protect_en_q ==
            ($past(opt_word0[2:0]) != 3'h0))
        else $error("code protection mismatch");

    a_timer_pin_sel: assert property (
        s_capture |-> timer_clk_in_sel_q == $past(opt_word1[11]))
        else $error("timer pin function wrong");

    a_halt_permit: assert property (
        s_capture |-> halt_allow_q == !$past(opt_word1[9]))
        else $error("halt permission wrong");

    a_trim_nominal: assert property (
        s_capture ##0 rc_trim_code_q == 5'h00 |-> rc_trim_rank_q == 5'h10)
        else $error("nominal trim not at mid rank");

    a_trim_order: assert property (
        s_capture ##0 rc_trim_code_q == 5'h1F |-> rc_trim_rank_q == 5'h00)
        else $error("slowest trim code not rank zero");

    a_rc_nominal: assert property (
        settings_valid_q && rc_freq_sel_q == 2'h3 |->
            rc_nominal_khz_q == 15'h01C7)
        else $error("455 kHz selection wrong");

    a_lvr_disable: assert property (
        settings_valid_q && !lvr_en_q |-> lvr_trip_mv_q == 12'h7D0)
        else $error("disabled detector must leave 2.0 V point");

    a_lvr_hyst: assert property (
        settings_valid_q && lvr_en_q |-> lvr_release_mv_q > lvr_trip_mv_q)
        else $error("release level not above trip level");

    a_settings_hold: assert property (
        s_held |-> $stable(clk_src_q) && $stable(code_protect_en_q) &&
            $stable(rc_trim_code_q) && $stable(lvr_en_q) &&
            $stable(customer_id_q))
        else $error("settings changed after capture");

    a_id_hidden: assert property (
        bus_take && !hwrite && haddr[11:0] == `OWD_ADDR_ID &&
            code_protect_en_q |=> hrdata == 32'h0000_0000)
        else $error("customer ID visible while protected");

    a_ready_okay: assert property (
        hreadyout && !hresp)
        else $error("slave must be ready with OKAY");

endmodule

/* File: verification/tb_owd_top.sv */
// Self-checking bench for the option word decoder top.
// Assumes owd_pkg and owd_top from src/ are compiled first.
`timescale 1ns/1ps

`define CHK(nm, e, g) \
    begin \
        checked++; \
        if ((g) !== (e)) \
        begin \
            err_count++; \
            $display("CHECK FAILED %s exp %0h got %0h", nm, (e), (g)); \
        end \
    end

module tb_owd_top;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic [12:0] opt_word0 = 13'h0000;
    logic [12:0] opt_word1 = 13'h1000;
    logic [12:0] opt_word2 = 13'h0000;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    wire hready;
    logic hreadyout, hresp, osc_out_en_q, second_osc_gpio_q;
    logic code_protect_en_q, timer_clk_in_sel_q, halt_allow_q, lvr_en_q;
    logic reserved_ok_q, settings_valid_q;
    logic [31:0] hrdata;
    owd_pkg::owd_clk_src_type clk_src_q;
    logic [4:0] rc_trim_code_q, rc_trim_rank_q;
    logic [1:0] rc_freq_sel_q;
    logic [14:0] rc_nominal_khz_q;
    logic [11:0] lvr_trip_mv_q, lvr_release_mv_q;
    logic [12:0] customer_id_q;
    int err_count = 0;
    int checked = 0;

    // ****************************************************************
    // Clock, bus ready loop-back and the design
    // ****************************************************************
    // Single slave, so its ready is the bus ready
    always #10 hclk = ~hclk;
    assign hready = hreadyout;

    owd_top uut
    (
        .hclk(hclk), .hresetn(hresetn), .opt_word0(opt_word0),
        .opt_word1(opt_word1), .opt_word2(opt_word2), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .clk_src_q(clk_src_q),
        .osc_out_en_q(osc_out_en_q), .second_osc_gpio_q(second_osc_gpio_q),
        .code_protect_en_q(code_protect_en_q),
        .timer_clk_in_sel_q(timer_clk_in_sel_q),
        .halt_allow_q(halt_allow_q), .rc_trim_code_q(rc_trim_code_q),
        .rc_trim_rank_q(rc_trim_rank_q), .rc_freq_sel_q(rc_freq_sel_q),
        .rc_nominal_khz_q(rc_nominal_khz_q), .lvr_en_q(lvr_en_q),
        .lvr_trip_mv_q(lvr_trip_mv_q), .lvr_release_mv_q(lvr_release_mv_q),
        .customer_id_q(customer_id_q), .reserved_ok_q(reserved_ok_q),
        .settings_valid_q(settings_valid_q)
    );

    // ****************************************************************
    // Bus tasks and verdict
    // ****************************************************************
    task automatic close_out;
        if (err_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Bounded wait for ready; a hang counts as a mismatch
    task automatic wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'h1 && n < 50);
        if (hreadyout !== 1'h1)
        begin
            err_count++;
            close_out;
        end
    endtask

    // One single word transfer; read data taken at the data phase edge
    task automatic ahb(input logic [11:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= {20'h00000, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy;
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy;
        rd = hrdata;
        `CHK("hresp", 1'h0, hresp)
    endtask

    task automatic rd_chk(input string nm, input logic [11:0] a,
                          input logic [31:0] e);
        logic [31:0] d;
        ahb(a, 1'h0, 32'h00000000, d);
        `CHK(nm, e, d)
    endtask

    // ****************************************************************
    // Sweep of option word settings, one reset each
    // ****************************************************************
    initial
    begin
        logic [4:0] trim [8];
        logic [4:0] rank [8];
        logic [14:0] khz [4];
        logic [11:0] trip [4];
        logic [11:0] rel [4];
        logic [2:0] m, src;
        logic [1:0] lv, rf;
        logic pr, rok;
        logic [31:0] d;
        trim = '{5'h1F, 5'h18, 5'h0F, 5'h08, 5'h00, 5'h07, 5'h10, 5'h17};
        rank = '{5'h00, 5'h07, 5'h08, 5'h0F, 5'h10, 5'h17, 5'h18, 5'h1F};
        khz = '{15'h0FA0, 15'h3E80, 15'h0DFC, 15'h01C7};
        trip = '{12'h7D0, 12'hA28, 12'hCE4, 12'hED8};
        rel = '{12'h7D0, 12'hAF0, 12'hD7A, 12'hF3C};
        for (int i = 0; i < 8; i++)
        begin
            m = i[2:0];
            lv = i[2:1];
            rf = i[1:0];
            pr = (i != 0);
            rok = (i < 6);
            // Case 6 sets the must-be-zero bit, case 7 clears the other
            hresetn <= 1'h0;
            opt_word0 <= {7'h00, m, m};
            opt_word1 <= {i != 7, i[0], i == 6, i[1], trim[i], rf, lv};
            opt_word2 <= 13'h0A50 + 13'(i);
            repeat (20) @(posedge hclk);
            `CHK("valid_rst", 1'h0, settings_valid_q)
            hresetn <= 1'h1;
            repeat (2) @(posedge hclk);
            src = (m < 3'h4) ? m : (m[1] ? 3'h5 : 3'h4);
            `CHK("clk_src", src, clk_src_q)
            `CHK("osc_out", m[2] & m[0], osc_out_en_q)
            `CHK("osc_gpio", m[2] & ~m[0], second_osc_gpio_q)
            `CHK("protect", pr, code_protect_en_q)
            `CHK("res_ok", rok, reserved_ok_q)
            `CHK("tpin", i[0], timer_clk_in_sel_q)
            `CHK("halt", ~i[1], halt_allow_q)
            `CHK("trim", trim[i], rc_trim_code_q)
            `CHK("rank", rank[i], rc_trim_rank_q)
            `CHK("khz", khz[rf], rc_nominal_khz_q)
            `CHK("lvr_en", lv != 2'h0, lvr_en_q)
            `CHK("trip", trip[lv], lvr_trip_mv_q)
            `CHK("rel", rel[lv], lvr_release_mv_q)
            `CHK("id", 13'h0A50 + 13'(i), customer_id_q)
            `CHK("rcf", rf, rc_freq_sel_q)
            `CHK("valid", 1'h1, settings_valid_q)
            // Words reach the bus as decoded settings, and word 2 as the ID when unprotected, once enabled
            rd_chk("osc_off", 12'h000, 32'h00000000);
            ahb(12'h010, 1'h1, 32'h00000001, d);
            rd_chk("ctrl", 12'h010, 32'h00000001);
            rd_chk("osc", 12'h000,
                   {25'h0, m[2] & ~m[0], m[2] & m[0], 2'h0, src});
            rd_chk("cfg", 12'h004, {5'h00, 1'h1, rok, khz[rf], rf, rank[i],
                   ~i[1], i[0], pr});
            rd_chk("lvr", 12'h008,
                   {7'h00, rel[lv], trip[lv], lv != 2'h0});
            rd_chk("id_bus", 12'h00C,
                   pr ? 32'h0 : {19'h0, 13'h0A50 + 13'(i)});
            rd_chk("unmapped", 12'h020, 32'h00000000);
            // Later input changes must not leak through
            opt_word0 <= ~opt_word0;
            opt_word1 <= ~opt_word1;
            opt_word2 <= ~opt_word2;
            repeat (3) @(posedge hclk);
            `CHK("hold_src", src, clk_src_q)
            `CHK("hold_prot", pr, code_protect_en_q)
            `CHK("hold_trim", trim[i], rc_trim_code_q)
            `CHK("hold_id", 13'h0A50 + 13'(i), customer_id_q)
        end
        close_out;
    end
endmodule
